// ---- design/spms_port.sv ----
// Serial master/slave byte port with loose control and status bits.
// Assumes slave-side pins are asynchronous and sampled by the system clock.
module spms_port import spms_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	// Configuration
	input wire logic cfg_master,
	input wire logic [2:0] cfg_rate,
	input wire logic [1:0] cfg_mode,
	input wire logic cfg_lsb_first,
	input wire logic cfg_irq_on_done,
	// Control: enable, start pulse, tx write pulse, done clear pulse
	input wire logic ctl_enable,
	input wire logic ctl_start,
	input wire logic ctl_tx_write,
	input wire logic ctl_done_clear,
	input wire logic [7:0] tx_data,
	// Status: done, busy, tx empty, overrun
	output logic sts_done,
	output logic sts_busy,
	output logic sts_tx_empty,
	output logic sts_overrun,
	output logic [7:0] rx_data,
	output logic irq,
	// Pins
	output logic sck_out,
	output logic sck_oe,
	input wire logic sck_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic miso_in,
	input wire logic ss_n_in
);
	//----------------------------------------
	// Pin synchronisers
	//----------------------------------------
	logic sck_s, mosi_s, miso_s, ss_n_s;
	spms_sync #(.INIT(1'b0)) u_sync_sck (.clock(clock), .rst_n(rst_n), .async_in(sck_in), .sync_out(sck_s));
	spms_sync #(.INIT(1'b0)) u_sync_mosi (.clock(clock), .rst_n(rst_n), .async_in(mosi_in), .sync_out(mosi_s));
	spms_sync #(.INIT(1'b0)) u_sync_miso (.clock(clock), .rst_n(rst_n), .async_in(miso_in), .sync_out(miso_s));
	spms_sync #(.INIT(1'b1)) u_sync_ss (.clock(clock), .rst_n(rst_n), .async_in(ss_n_in), .sync_out(ss_n_s));

	logic cpol, cpha;
	// Bit 0 polarity, bit 1 phase: modes 0 and 1 queue at select
	assign cpol = cfg_mode[0];
	assign cpha = cfg_mode[1];

	//----------------------------------------
	// Edge detection on slave-side pins
	//----------------------------------------
	logic sck_d, ss_n_d;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sck_d <= 1'b0;
			ss_n_d <= 1'b1;
		end else begin
			sck_d <= sck_s;
			ss_n_d <= ss_n_s;
		end
	end
	logic slv_sel, ss_fall, s_rise, s_fall, s_lead, s_trail;
	assign slv_sel = !cfg_master && ctl_enable && !ss_n_s;
	assign ss_fall = ss_n_d && !ss_n_s;
	assign s_rise = !sck_d && sck_s;
	assign s_fall = sck_d && !sck_s;
	assign s_lead = slv_sel && (cpol ? s_fall : s_rise);
	assign s_trail = slv_sel && (cpol ? s_rise : s_fall);

	//----------------------------------------
	// Master clock generator
	//----------------------------------------
	spms_state_t state;
	logic tick;
	logic [3:0] m_edges;
	spms_rate u_rate (.clock(clock), .rst_n(rst_n), .clear(state == SPMS_IDLE), .rate_sel(cfg_rate), .tick(tick));

	logic tx_full;
	logic [7:0] tx_hold;
	logic m_go;
	assign m_go = cfg_master && ctl_enable && (ctl_start || tx_full) && state == SPMS_IDLE;

	always_ff @(posedge clock) begin
		if (!rst_n || !cfg_master || !ctl_enable) begin
			state <= SPMS_IDLE;
		end else begin
			case (state)
				SPMS_IDLE: begin
					if (m_go) begin
						state <= SPMS_LEAD;
					end
				end
				SPMS_LEAD: begin
					if (tick) begin
						state <= SPMS_TRAIL;
					end
				end
				SPMS_TRAIL: begin
					if (tick) begin
						state <= (m_edges == 4'(SPMS_BITS - 1)) ? SPMS_IDLE : SPMS_LEAD;
					end
				end
				default: state <= SPMS_IDLE;
			endcase
		end
	end

	logic m_lead, m_trail;
	assign m_lead = state == SPMS_LEAD && tick;
	assign m_trail = state == SPMS_TRAIL && tick;

	always_ff @(posedge clock) begin
		if (!rst_n || state == SPMS_IDLE) begin
			m_edges <= SPMS_CNT_RESET;
		end else if (m_trail) begin
			m_edges <= m_edges + 4'h1;
		end
	end

	// Serial clock toggles each half-period, idles at polarity
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sck_out <= 1'b0;
		end else if (state == SPMS_IDLE) begin
			sck_out <= cpol;
		end else if (tick) begin
			sck_out <= !sck_out;
		end
	end
	assign sck_oe = cfg_master && ctl_enable;
	// No slave-select output exists in master role.

	//----------------------------------------
	// Shift register shared by both roles
	//----------------------------------------
	logic lead, trail, launch, capture, load_now;
	logic [7:0] shreg;
	logic [3:0] bits_in;
	logic in_bit, out_bit;
	assign lead = cfg_master ? m_lead : s_lead;
	assign trail = cfg_master ? m_trail : s_trail;
	// Phase 0 captures on leading, launches on trailing.
	assign capture = cpha ? trail : lead;
	assign launch = cpha ? lead : trail;
	assign in_bit = cfg_master ? miso_s : mosi_s;
	assign out_bit = cfg_lsb_first ? shreg[0] : shreg[7];
	// Byte loaded at master start, or at select fall in slave role
	assign load_now = m_go || (!cfg_master && ctl_enable && ss_fall);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shreg <= SPMS_BYTE_RESET;
		end else if (load_now) begin
			shreg <= tx_full ? tx_hold : 8'hff;
		end else if (capture) begin
			shreg <= cfg_lsb_first ? {in_bit, shreg[7:1]} : {shreg[6:0], in_bit};
		end
	end

	// Output bit register: queued at load in phase 0, else launched
	logic dout;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dout <= 1'b1;
		end else if (load_now && !cpha) begin
			dout <= tx_full ? (cfg_lsb_first ? tx_hold[0] : tx_hold[7]) : 1'b1;
		end else if (launch && bits_in != 4'h0 && bits_in != 4'(SPMS_BITS)) begin
			dout <= out_bit;
		end else if (launch && cpha && bits_in == 4'h0) begin
			dout <= out_bit;
		end
	end
	assign mosi_out = dout;
	assign mosi_oe = cfg_master && ctl_enable;
	assign miso_out = dout;
	assign miso_oe = slv_sel;

	// Bits captured in the current byte
	logic byte_done;
	assign byte_done = capture && bits_in == 4'(SPMS_BITS - 1);
	always_ff @(posedge clock) begin
		if (!rst_n || load_now || (!cfg_master && ss_n_s)) begin
			bits_in <= SPMS_CNT_RESET;
		end else if (byte_done) begin
			bits_in <= SPMS_CNT_RESET;
		end else if (capture) begin
			bits_in <= bits_in + 4'h1;
		end
	end

	//----------------------------------------
	// Transmit holding and receive data
	//----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_full <= 1'b0;
			tx_hold <= SPMS_BYTE_RESET;
		end else if (ctl_tx_write) begin
			tx_full <= 1'b1;
			tx_hold <= tx_data;
		end else if (load_now) begin
			tx_full <= 1'b0;
		end
	end
	assign sts_tx_empty = !tx_full;

	logic [7:0] rx_next;
	assign rx_next = cfg_lsb_first ? {in_bit, shreg[7:1]} : {shreg[6:0], in_bit};
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_data <= SPMS_BYTE_RESET;
		end else if (byte_done) begin
			rx_data <= rx_next;
		end
	end

	//----------------------------------------
	// Status bits, set wins over clear
	//----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sts_done <= 1'b0;
		end else if (byte_done) begin
			sts_done <= 1'b1;
		end else if (ctl_done_clear) begin
			sts_done <= 1'b0;
		end
	end
	// Overrun only flags a slave byte arriving with done still set
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sts_overrun <= 1'b0;
		end else if (byte_done && sts_done && !cfg_master) begin
			sts_overrun <= 1'b1;
		end else if (ctl_done_clear) begin
			sts_overrun <= 1'b0;
		end
	end
	assign sts_busy = cfg_master ? state != SPMS_IDLE : slv_sel;
	// Interrupt source: done or tx empty
	assign irq = ctl_enable && (cfg_irq_on_done ? sts_done : !tx_full);

	//----------------------------------------
	// Assertions
	//----------------------------------------
	property p_eight_clocks;
		@(posedge clock) disable iff (!rst_n) m_trail && m_edges == 4'h7 |=> state == SPMS_IDLE;
	endproperty
	a_eight_clocks: assert property (p_eight_clocks) else $error("master byte not eight clocks");
	property p_done_set;
		@(posedge clock) disable iff (!rst_n) byte_done |=> sts_done;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not set after byte");
	property p_idle_pol;
		@(posedge clock) disable iff (!rst_n) cfg_master && $past(state) == SPMS_IDLE && state == SPMS_IDLE
			|-> sck_out == $past(cpol);
	endproperty
	a_idle_pol: assert property (p_idle_pol) else $error("idle clock wrong polarity");
	property p_slave_quiet;
		@(posedge clock) disable iff (!rst_n) !cfg_master && ss_n_s |-> !miso_oe && !capture;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("slave active while deselected");
	property p_slave_no_clock;
		@(posedge clock) disable iff (!rst_n) !cfg_master |-> !sck_oe && !mosi_oe && state == SPMS_IDLE;
	endproperty
	a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drove clock");
	property p_edges_split;
		@(posedge clock) disable iff (!rst_n) !(launch && capture);
	endproperty
	a_edges_split: assert property (p_edges_split) else $error("launch and capture coincide");
	property p_rx_update;
		@(posedge clock) disable iff (!rst_n) byte_done |=> rx_data == $past(rx_next);
	endproperty
	a_rx_update: assert property (p_rx_update) else $error("receive byte not stored");
	property p_start_busy;
		@(posedge clock) disable iff (!rst_n) m_go |=> sts_busy [*2];
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("master start not busy");
	property p_filler;
		@(posedge clock) disable iff (!rst_n) load_now && !tx_full |=> shreg == 8'hff;
	endproperty
	a_filler: assert property (p_filler) else $error("filler byte not loaded");

	c_master_byte: cover property (@(posedge clock) disable iff (!rst_n) cfg_master && byte_done);
	c_slave_byte: cover property (@(posedge clock) disable iff (!rst_n) !cfg_master && byte_done);
	c_overrun: cover property (@(posedge clock) disable iff (!rst_n) $rose(sts_overrun));
endmodule // spms_port

// ---- pkg/spms_pkg.sv ----
// Constants and types for the serial master/slave port.
// Assumes a single 100 MHz system clock domain.
package spms_pkg;
	localparam int unsigned SPMS_CLK_HZ = 100_000_000;
	localparam int unsigned SPMS_BITS = 8;
	// Serial clock rate range in Hz
	localparam int unsigned SPMS_SCK_MIN_HZ = 46_900;
	localparam int unsigned SPMS_SCK_MAX_HZ = 12_000_000;
	// Half-period divider counts: shortest rounds up, longest rounds down
	localparam int unsigned SPMS_HALF_MIN = (SPMS_CLK_HZ + 2 * SPMS_SCK_MAX_HZ - 1) / (2 * SPMS_SCK_MAX_HZ);
	localparam int unsigned SPMS_HALF_MAX = SPMS_CLK_HZ / (2 * SPMS_SCK_MIN_HZ);
	localparam int unsigned SPMS_DIV_W = 11;
	localparam logic [SPMS_DIV_W-1:0] SPMS_DIV_RESET = SPMS_DIV_W'(SPMS_HALF_MAX);
	localparam logic [2:0] SPMS_RATE_RESET = 3'h7;
	localparam logic [1:0] SPMS_MODE_RESET = 2'h0;
	localparam logic [3:0] SPMS_CNT_RESET = 4'h0;
	localparam logic [7:0] SPMS_BYTE_RESET = 8'h00;

	typedef enum logic [2:0] {
		SPMS_IDLE = 3'b001,
		SPMS_LEAD = 3'b010,
		SPMS_TRAIL = 3'b100
	} spms_state_t;

	// Rate select to half-period count: 8 rates, from fastest up to slowest
	function automatic logic [SPMS_DIV_W-1:0] spms_half(input logic [2:0] sel);
		logic [SPMS_DIV_W-1:0] h;
		h = SPMS_DIV_W'(SPMS_HALF_MIN) << sel;
		if (sel == 3'h7 || h > SPMS_DIV_W'(SPMS_HALF_MAX)) begin
			h = SPMS_DIV_W'(SPMS_HALF_MAX);
		end
		return h;
	endfunction
endpackage

// ---- design/spms_sync.sv ----
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the output is read only after the second stage.
module spms_sync import spms_pkg::*; #(
	parameter logic INIT = 1'b0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic stage;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stage <= INIT;
			sync_out <= INIT;
		end else begin
			stage <= async_in;
			sync_out <= stage;
		end
	end
endmodule // spms_sync

// ---- design/spms_rate.sv ----
// Serial clock half-period enable divider for master role.
// Assumes clear is held while no transfer is active.
module spms_rate import spms_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic [2:0] rate_sel,
	output logic tick
);
	logic [SPMS_DIV_W-1:0] count;

	always_ff @(posedge clock) begin
		if (!rst_n || clear) begin
			count <= SPMS_DIV_W'(1);
			tick <= 1'b0;
		end else if (count >= spms_half(rate_sel)) begin
			count <= SPMS_DIV_W'(1);
			tick <= 1'b1;
		end else begin
			count <= count + SPMS_DIV_W'(1);
			tick <= 1'b0;
		end
	end
endmodule // spms_rate

// ---- bench/spms_slave_model.sv ----
// External serial slave on the port's wires, for master-role runs.
// Assumes select comes from a bench pin acting as firmware GPIO; MSB first.
module spms_slave_model (
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic [1:0] mode,
	input wire logic [7:0] load,
	output logic miso,
	output logic [7:0] got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial begin
		miso = 1'b0;
		got = 8'h00;
		sh = 8'h00;
	end
	always @(negedge cs_n) begin
		sh = load;
		miso = mode[1] ? ~load[7] : load[7];
	end
	// Released line shows the inverse of its last value
	always @(posedge cs_n) miso = ~miso;
	always @(sck) begin
		if (!cs_n && ((sck != mode[0]) ^ mode[1])) begin
			got = {got[6:0], mosi};
		end else if (!cs_n && mode[1]) begin
			miso = sh[7];
			sh = sh << 1;
		end else if (!cs_n) begin
			sh = sh << 1;
			miso = sh[7];
		end
	end
endmodule // spms_slave_model

// ---- bench/spms_port_tb_top.sv ----
// Self-checking bench for the serial master/slave port.
// Assumes the slave model on the wires; the bench itself plays external master.
module spms_port_tb_top import spms_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst_n = 1'b0, cfg_master = 1'b1, cfg_lsb_first = 1'b0, cfg_irq_on_done = 1'b1;
	logic ctl_enable = 1'b1, ctl_start = 1'b0, ctl_tx_write = 1'b0, ctl_done_clear = 1'b0;
	logic [2:0] cfg_rate = 3'h0;
	logic [1:0] cfg_mode = 2'h0;
	logic [7:0] tx_data = 8'h00, m_load = 8'h00, rx_data, m_got, got;
	logic sts_done, sts_busy, sts_tx_empty, sts_overrun, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic b_sck = 1'b0, b_mosi = 1'b0, ss_n = 1'b1, cs_n = 1'b1, m_miso, sck_w, mosi_w, miso_w;
	int n_errors = 0, checks = 0, cyc = 0, n_edge = 0;
	assign sck_w = sck_oe ? sck_out : b_sck;
	assign mosi_w = mosi_oe ? mosi_out : b_mosi;
	assign miso_w = miso_oe ? miso_out : m_miso;
	always #5 clock = ~clock;
	always @(sck_w) n_edge++;
	spms_port DUT (.clock(clock), .rst_n(rst_n), .cfg_master(cfg_master), .cfg_rate(cfg_rate),
		.cfg_mode(cfg_mode), .cfg_lsb_first(cfg_lsb_first), .cfg_irq_on_done(cfg_irq_on_done),
		.ctl_enable(ctl_enable), .ctl_start(ctl_start), .ctl_tx_write(ctl_tx_write),
		.ctl_done_clear(ctl_done_clear), .tx_data(tx_data), .sts_done(sts_done), .sts_busy(sts_busy),
		.sts_tx_empty(sts_tx_empty), .sts_overrun(sts_overrun), .rx_data(rx_data), .irq(irq),
		.sck_out(sck_out), .sck_oe(sck_oe), .sck_in(sck_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
		.mosi_in(mosi_w), .miso_out(miso_out), .miso_oe(miso_oe), .miso_in(miso_w), .ss_n_in(ss_n));
	spms_slave_model PEER (.cs_n(cs_n), .sck(sck_w), .mosi(mosi_w), .mode(cfg_mode), .load(m_load),
		.miso(m_miso), .got(m_got));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] rev(input logic [7:0] v, input logic on);
		return on ? {<<{v}} : v;
	endfunction
	function automatic logic [15:0] exp_half(input logic [2:0] r);
		return (r == 3'h7) ? 16'(SPMS_HALF_MAX) : 16'(SPMS_HALF_MIN) << r;
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("Counts: %0d checks, %0d mismatches", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	task automatic m_xfer(input logic [1:0] m, input logic [2:0] r, input logic l, input logic [7:0] b,
		input logic [7:0] s, input logic f);
		int k;
		logic p;
		cfg_master = 1'b1;
		cfg_mode = m;
		cfg_rate = r;
		cfg_lsb_first = l;
		cfg_irq_on_done = 1'($urandom);
		m_load = s;
		repeat (4) @(negedge clock);
		chk("idle clock", sck_w, m[0]);
		cs_n = 1'b0;
		n_edge = 0;
		tx_data = b;
		if (f) pulse(ctl_start);
		else pulse(ctl_tx_write);
		for (int j = 0; j < 2; j++) begin
			p = sck_w;
			k = 0;
			while (sck_w === p && k < 5000) begin
				@(negedge clock);
				k++;
			end
		end
		chk("half period", 16'(k), exp_half(r));
		chk("busy", sts_busy, 1'b1);
		k = 0;
		while ((sts_done !== 1'b1 || sts_busy !== 1'b0) && k < 40000) begin
			@(negedge clock);
			k++;
		end
		@(negedge clock);
		chk("done in time", sts_done, 1'b1);
		chk("tx empty", sts_tx_empty, 1'b1);
		chk("clock edges", 16'(n_edge), 16'h10);
		chk("peer byte", m_got, f ? 8'hff : rev(b, l));
		chk("rx byte", rx_data, rev(s, l));
		chk("overrun", sts_overrun, 1'b0);
		chk("irq", irq, 1'b1);
		cs_n = 1'b1;
		pulse(ctl_done_clear);
		chk("done clear", sts_done, 1'b0);
		chk("irq after clear", irq, !cfg_irq_on_done);
	endtask
	task automatic s_xfer(input logic [1:0] m, input logic [7:0] b, input logic [7:0] d, input logic sel,
		input logic clr);
		cfg_master = 1'b0;
		cfg_mode = m;
		cfg_lsb_first = 1'b0;
		b_sck = m[0];
		tx_data = d;
		pulse(ctl_tx_write);
		chk("slave tx held", sts_tx_empty, 1'b0);
		if (clr) pulse(ctl_done_clear);
		repeat (4) @(negedge clock);
		ss_n = !sel;
		b_mosi = b[7];
		repeat (8) @(negedge clock);
		chk("slave drive", miso_oe, sel);
		for (int i = 7; i >= 0; i--) begin
			if (!m[1]) got[i] = miso_w;
			if (m[1]) b_mosi = b[i];
			b_sck = ~b_sck;
			repeat (8) @(negedge clock);
			if (m[1]) got[i] = miso_w;
			b_sck = ~b_sck;
			if (!m[1] && i > 0) b_mosi = b[i-1];
			repeat (8) @(negedge clock);
		end
		ss_n = 1'b1;
		b_mosi = ~b_mosi;
		repeat (4) @(negedge clock);
		chk("slave done", sts_done, sel);
		chk("slave overrun", sts_overrun, sel && !clr);
		if (sel) begin
			chk("slave rx", rx_data, b);
			chk("slave tx", got, d);
		end
	endtask
	// ----------------------------------------
	// Sequence and timeout
	// ----------------------------------------
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		void'($urandom(85));
		repeat (20) @(negedge clock);
		chk("reset done", sts_done, 1'b0);
		chk("reset empty", sts_tx_empty, 1'b1);
		chk("reset rx", rx_data, 8'h00);
		chk("reset sck", sck_out, 1'b0);
		rst_n = 1'b1;
		@(negedge clock);
		$display("Test reset done");
		m_xfer(2'h0, 3'h7, 1'b0, 8'ha5, 8'h3c, 1'b0);
		m_xfer(2'h3, 3'h0, 1'b0, 8'h00, 8'h81, 1'b1);
		for (int i = 0; i < 10; i++) m_xfer(2'($urandom), 3'($urandom % 3), 1'($urandom), 8'($urandom), 8'($urandom), 1'b0);
		$display("Test master done");
		for (int i = 0; i < 4; i++) s_xfer(2'(i), 8'($urandom), 8'($urandom), 1'b1, i != 3);
		s_xfer(2'h0, 8'h5a, 8'hc3, 1'b0, 1'b1);
		$display("Test slave done");
		test_done;
	end
endmodule // spms_port_tb_top
